// ### spr_pkg.sv
// Package with constants and opcodes for the sector guard map command block.
// Assumes a single ref_clk domain at 250 MHz; serial pins arrive asynchronously.
package spr_pkg;

    localparam int          REF_CLK_MHZ        = 250;
    localparam int          MAP_BYTES          = 8;
    localparam int          XFER_BYTES         = 4;
    localparam int          PTR_W              = 3;
    localparam logic [7:0]  OP_PREFIX_0        = 8'h3d;
    localparam logic [7:0]  OP_PREFIX_1        = 8'h2a;
    localparam logic [7:0]  OP_PREFIX_2        = 8'h7f;
    localparam logic [7:0]  OP_ERASE_3         = 8'hcf;
    localparam logic [7:0]  OP_PROGRAM_3       = 8'hfc;
    localparam logic [7:0]  OP_READ            = 8'h32;
    localparam logic [7:0]  BYTE_ERASED        = 8'hff;
    localparam logic [7:0]  BYTE_SHIPPED       = 8'h00;
    localparam logic [7:0]  S0A_MASK           = 8'hc0;
    localparam logic [7:0]  S0B_MASK           = 8'h30;
    localparam logic [63:0] GUARD_MAP_RESET    = 64'h0;
    localparam int          READ_DUMMY_BYTES   = 3;
    localparam int          HDR_BYTES          = 4;
    localparam int          ERASE_TIME_US      = 4000;
    localparam int          PROGRAM_TIME_US    = 4000;
    localparam int          ERASE_CYCLES       = ERASE_TIME_US * REF_CLK_MHZ;
    localparam int          PROGRAM_CYCLES     = PROGRAM_TIME_US * REF_CLK_MHZ;

endpackage : spr_pkg

// ### spr_byte_if.sv
// Interface carrying received bytes and outgoing bits between the shifter and the core.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ns
interface spr_byte_if;
    logic       sel;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       fall_edge;
    logic       tx_load;
    logic [7:0] tx_byte;
    logic       so_bit;

    modport shifter (output sel, output byte_valid, output byte_data, output fall_edge,
                     input tx_load, input tx_byte, output so_bit);
    modport core (input sel, input byte_valid, input byte_data, input fall_edge,
                  output tx_load, output tx_byte, input so_bit);
endinterface : spr_byte_if

// ### spr_shifter.sv
// Serial shifter: synchronises pins, assembles bytes on rising clock edges, shifts on falling.
// Assumes mode 0 or 3 serial framing, msb first, pin clock much slower than ref_clk.
`timescale 1ns/1ns
module spr_shifter (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic cs_n_pin,
    input  wire logic sck_pin,
    input  wire logic si_pin,
    spr_byte_if.shifter bus
);
    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] ck_s;
        logic [1:0] si_s;
        logic       ck_d;
        logic [2:0] bit_cnt;
        logic [7:0] rx;
        logic [7:0] tx;
        logic       valid;
        logic       fall;
        logic       fresh;
    } spr_shift_t;

    spr_shift_t st, next_st;

    always_comb begin
        next_st = st;
        next_st.cs_s = {st.cs_s[0], cs_n_pin};
        next_st.ck_s = {st.ck_s[0], sck_pin};
        next_st.si_s = {st.si_s[0], si_pin};
        next_st.ck_d = st.ck_s[1];
        next_st.valid = 1'b0;
        next_st.fall = 1'b0;
        if (st.cs_s[1]) begin
            next_st.bit_cnt = 3'h0;
        end else begin
            if (st.ck_s[1] && !st.ck_d) begin
                next_st.rx = {st.rx[6:0], st.si_s[1]};
                next_st.bit_cnt = st.bit_cnt + 3'h1;
                if (st.bit_cnt == 3'h7) begin
                    next_st.valid = 1'b1;
                end
            end
            if (!st.ck_s[1] && st.ck_d) begin
                next_st.fall = 1'b1;
                if (st.fresh) begin
                    next_st.fresh = 1'b0;
                end else begin
                    next_st.tx = {st.tx[6:0], 1'b0};
                end
            end
        end
        // A fresh byte keeps its msb on the pin through the falling edge that follows it.
        if (bus.tx_load) begin
            next_st.tx = bus.tx_byte;
            next_st.fresh = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '{cs_s: 2'h3, ck_s: 2'h0, si_s: 2'h0, ck_d: 1'b0, bit_cnt: 3'h0,
                    rx: 8'h00, tx: 8'h00, valid: 1'b0, fall: 1'b0, fresh: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign bus.sel        = !st.cs_s[1];
    assign bus.byte_valid = st.valid;
    assign bus.byte_data  = st.rx;
    assign bus.fall_edge  = st.fall;
    assign bus.so_bit     = st.tx[7];
endmodule : spr_shifter

// ### spr_guard_map.sv
// Top of the guard map command block: decodes commands, times erase and program cycles,
// and exposes the map, busy and per-sector guard outputs. Pins are asynchronous.
`timescale 1ns/1ns
module spr_guard_map
    import spr_pkg::*;
#(
    parameter int ERASE_CNT   = spr_pkg::ERASE_CYCLES,
    parameter int PROGRAM_CNT = spr_pkg::PROGRAM_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        cs_n_pin,
    input  wire logic        sck_pin,
    input  wire logic        si_pin,
    input  wire logic        wp_n_pin,
    input  wire logic        protect_enable,
    output logic             so,
    output logic             so_oe,
    output logic             busy,
    output logic [63:0]      sector_guard_map,
    output logic [8:0]       sector_guarded,
    output logic             buffer_clobber
);
    import spr_pkg::*;

    initial begin
        if (ERASE_CNT < 1 || PROGRAM_CNT < 1 || ERASE_CNT > 32'h7fffffff) begin
            $error("spr_guard_map: cycle counts out of range.");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_HDR   = 6'b000010,
        ST_DATA  = 6'b000100,
        ST_READ  = 6'b001000,
        ST_SKIP  = 6'b010000,
        ST_WORK  = 6'b100000
    } spr_state_t;

    typedef enum logic [1:0] {
        CMD_NONE  = 2'h0,
        CMD_ERASE = 2'h1,
        CMD_PROG  = 2'h2
    } spr_cmd_t;

    typedef struct packed {
        spr_state_t  state;
        spr_cmd_t    cmd;
        logic [1:0]  wp_s;
        logic [2:0]  hdr_cnt;
        logic [2:0]  wr_ptr;
        logic [2:0]  rd_ptr;
        logic [2:0]  bit_cnt;
        logic [31:0] timer;
        logic [63:0] map;
        logic [63:0] stage;
        logic        oe;
        logic        load;
        logic [7:0]  tx;
        logic        clobber;
    } spr_core_t;

    spr_core_t st, next_st;
    spr_byte_if link ();

    spr_shifter u_shifter (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .cs_n_pin (cs_n_pin),
        .sck_pin  (sck_pin),
        .si_pin   (si_pin),
        .bus      (link)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////

    logic       wp_active;
    logic [7:0] map_byte;

    assign wp_active = !st.wp_s[1];
    assign map_byte  = st.map[{st.rd_ptr, 3'h0} +: 8];

    always_comb begin
        next_st = st;
        next_st.wp_s = {st.wp_s[0], wp_n_pin};
        next_st.load = 1'b0;
        next_st.clobber = 1'b0;
        unique case (st.state)
            ST_IDLE: begin
                next_st.oe = 1'b0;
                next_st.hdr_cnt = 3'h0;
                next_st.cmd = CMD_NONE;
                if (link.byte_valid) begin
                    next_st.hdr_cnt = 3'h1;
                    if (link.byte_data == OP_PREFIX_0) begin
                        next_st.state = ST_HDR;
                    end else if (link.byte_data == OP_READ) begin
                        next_st.state = ST_READ;
                        next_st.rd_ptr = 3'h0;
                    end else begin
                        next_st.state = ST_SKIP;
                    end
                end
            end
            ST_HDR: begin
                if (!link.sel) begin
                    next_st.state = ST_IDLE;
                    if (st.cmd == CMD_ERASE && !wp_active) begin
                        next_st.state = ST_WORK;
                        next_st.timer = ERASE_CNT[31:0];
                    end
                end else if (link.byte_valid) begin
                    next_st.hdr_cnt = st.hdr_cnt + 3'h1;
                    if (st.hdr_cnt == 3'h1 && link.byte_data != OP_PREFIX_1) begin
                        next_st.state = ST_SKIP;
                    end else if (st.hdr_cnt == 3'h2 && link.byte_data != OP_PREFIX_2) begin
                        next_st.state = ST_SKIP;
                    end else if (st.hdr_cnt == 3'h3) begin
                        if (link.byte_data == OP_ERASE_3) begin
                            next_st.cmd = CMD_ERASE;
                        end else if (link.byte_data == OP_PROGRAM_3) begin
                            next_st.cmd = CMD_PROG;
                            next_st.state = ST_DATA;
                            next_st.wr_ptr = 3'h0;
                            next_st.stage = st.map;
                        end else begin
                            next_st.state = ST_SKIP;
                        end
                    end else if (st.hdr_cnt == 3'h4) begin
                        next_st.cmd = CMD_NONE;
                        next_st.state = ST_SKIP;
                    end
                end
            end
            ST_DATA: begin
                if (!link.sel) begin
                    next_st.state = ST_IDLE;
                    next_st.clobber = 1'b1;
                    if (!wp_active) begin
                        next_st.state = ST_WORK;
                        next_st.timer = PROGRAM_CNT[31:0];
                    end
                end else if (link.byte_valid) begin
                    next_st.stage[{st.wr_ptr, 3'h0} +: 8] = link.byte_data;
                    if (st.wr_ptr == 3'(XFER_BYTES - 1)) begin
                        next_st.wr_ptr = 3'h0;
                    end else begin
                        next_st.wr_ptr = st.wr_ptr + 3'h1;
                    end
                end
            end
            ST_READ: begin
                if (!link.sel) begin
                    next_st.state = ST_IDLE;
                    next_st.oe = 1'b0;
                end else begin
                    if (link.byte_valid && st.hdr_cnt != 3'h7) begin
                        next_st.hdr_cnt = st.hdr_cnt + 3'h1;
                    end
                    if (link.byte_valid && st.hdr_cnt >= 3'(READ_DUMMY_BYTES)) begin
                        next_st.oe = 1'b1;
                        next_st.load = 1'b1;
                        next_st.tx = map_byte;
                        next_st.rd_ptr = st.rd_ptr + 3'h1;
                    end
                end
            end
            ST_SKIP: begin
                if (!link.sel) begin
                    next_st.state = ST_IDLE;
                end
            end
            ST_WORK: begin
                if (st.timer <= 32'h1) begin
                    next_st.state = ST_IDLE;
                    if (st.cmd == CMD_ERASE) begin
                        next_st.map = {MAP_BYTES{BYTE_ERASED}};
                    end else begin
                        next_st.map = st.stage;
                    end
                end else begin
                    next_st.timer = st.timer - 32'h1;
                end
            end
            default: begin
                next_st.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '{state: ST_IDLE, cmd: CMD_NONE, wp_s: 2'h3, hdr_cnt: 3'h0, wr_ptr: 3'h0,
                    rd_ptr: 3'h0, bit_cnt: 3'h0, timer: 32'h0,
                    map: GUARD_MAP_RESET, stage: GUARD_MAP_RESET,
                    oe: 1'b0, load: 1'b0, tx: 8'h00, clobber: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////

    assign link.tx_load = st.load;
    assign link.tx_byte = st.tx;

    assign so               = (st.oe && link.sel) ? link.so_bit : 1'b0;
    assign so_oe            = st.oe && link.sel;
    assign busy             = st.state == ST_WORK;
    assign sector_guard_map = st.map;
    assign buffer_clobber   = st.clobber;

    // Guard outputs: index 0 is subsector 0a, 1 is 0b, 2..8 are sectors 1..7.
    assign sector_guarded[0] = protect_enable && ((st.map[7:0] & S0A_MASK) == S0A_MASK);
    assign sector_guarded[1] = protect_enable && ((st.map[7:0] & S0B_MASK) == S0B_MASK);
    genvar g;
    generate
        for (g = 1; g < MAP_BYTES; g++) begin : g_guard
            assign sector_guarded[g + 1] = protect_enable
                                           && (st.map[g*8 +: 8] == BYTE_ERASED);
        end
    endgenerate
endmodule : spr_guard_map

// ### spr_guard_map_asserts.sv
// Checker for the guard map command block, bound to its top module.
// Assumes one ref_clk domain and the cycle counts handed on by the bind.
`timescale 1ns/1ns
module spr_guard_map_asserts #(
    parameter int ERASE_CNT   = 20,
    parameter int PROGRAM_CNT = 20
) (
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        cs_n_pin,
    input wire logic        wp_n_pin,
    input wire logic        protect_enable,
    input wire logic        so,
    input wire logic        so_oe,
    input wire logic        busy,
    input wire logic [63:0] sector_guard_map,
    input wire logic [8:0]  sector_guarded,
    input wire logic        buffer_clobber
);
    import spr_pkg::*;
    int         busy_len;
    logic [8:0] exp_guard;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    // Counts the cycles of the running busy period.
    always_ff @(posedge ref_clk) begin
        busy_len <= (srst || !busy) ? 0 : busy_len + 1;
    end
    always_comb begin
        exp_guard[0] = protect_enable && (sector_guard_map[7:6] == 2'b11);
        exp_guard[1] = protect_enable && (sector_guard_map[5:4] == 2'b11);
        for (int k = 1; k < MAP_BYTES; k++) begin
            exp_guard[k + 1] = protect_enable && (sector_guard_map[8 * k +: 8] == BYTE_ERASED);
        end
    end
    a_so_quiet_off: assert property (!so_oe |-> !so)
        else $error("so active while not enabled");
    a_read_ends: assert property ($rose(cs_n_pin) |-> ##[1:6] !so_oe)
        else $error("so enable kept after deselect");
    a_busy_min: assert property ($rose(busy) |-> busy[*8])
        else $error("busy dropped early");
    a_busy_len: assert property ($fell(busy) |-> busy_len == ERASE_CNT || busy_len == PROGRAM_CNT)
        else $error("busy period of wrong length");
    a_map_at_end: assert property ($changed(sector_guard_map) |-> $past(busy) || $past(busy, 2))
        else $error("map changed outside a busy period");
    a_wp_blocks: assert property ((!wp_n_pin)[*8] |-> !$rose(busy))
        else $error("cycle started with write protect low");
    a_guard_view: assert property (sector_guarded == exp_guard)
        else $error("sector guard outputs differ from map");
    a_clobber_once: assert property (buffer_clobber |=> !buffer_clobber)
        else $error("buffer clobber longer than one cycle");
    a_busy_after_cs: assert property ($rose(busy) |-> cs_n_pin && $past(cs_n_pin, 3))
        else $error("busy rose without a deselect");
endmodule // spr_guard_map_asserts

bind spr_guard_map spr_guard_map_asserts #(.ERASE_CNT(ERASE_CNT), .PROGRAM_CNT(PROGRAM_CNT))
    i_chk (.ref_clk(ref_clk), .srst(srst), .cs_n_pin(cs_n_pin), .wp_n_pin(wp_n_pin),
    .protect_enable(protect_enable), .so(so), .so_oe(so_oe), .busy(busy),
    .sector_guard_map(sector_guard_map), .sector_guarded(sector_guarded),
    .buffer_clobber(buffer_clobber));

// ### spr_host_model.sv
// Host serial controller model framing commands for the guard map block.
// Assumes ref_clk at 4 ns; sck runs at 32 ns in frames and rests low between them.
`timescale 1ns/1ns
module spr_host_model (
    input  wire logic  ref_clk,
    input  wire logic  so,
    output logic       cs_n_pin,
    output logic       sck_pin,
    output logic       si_pin,
    output logic       rx_valid,
    output logic [7:0] rx_byte
);
    initial begin
        cs_n_pin = 1'b1;
        sck_pin  = 1'b0;
        si_pin   = 1'b1;
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
    end
    // Shifts a byte msb first and reads so late in each high phase.
    task automatic xfer(input logic [7:0] tx, input logic grab);
        for (int i = 7; i >= 0; i--) begin
            sck_pin = 1'b0;
            si_pin  = tx[i];
            repeat (4) @(negedge ref_clk);
            sck_pin = 1'b1;
            repeat (4) @(negedge ref_clk);
            rx_byte[i] = so;
        end
        rx_valid = grab;
        @(negedge ref_clk);
        rx_valid = 1'b0;
    endtask
    // Sends the header bytes, then clocks n_rd bytes back out of the block.
    task automatic send(input logic [7:0] hdr[$], input int n_rd);
        @(negedge ref_clk);
        cs_n_pin = 1'b0;
        repeat (4) @(negedge ref_clk);
        foreach (hdr[i]) xfer(hdr[i], 1'b0);
        repeat (n_rd) xfer(~hdr[0], 1'b1);
        sck_pin = 1'b0;
        repeat (4) @(negedge ref_clk);
        cs_n_pin = 1'b1;
        si_pin   = ~si_pin;
        repeat (8) @(negedge ref_clk);
    endtask
endmodule // spr_host_model

// ### spr_guard_map_test.sv
// Self-checking bench for the guard map command block with a host model on its pins.
// Assumes short erase and program counts so the run stays brief.
`timescale 1ns/1ns
module spr_guard_map_test;
    import spr_pkg::*;
    localparam int CNT = 20;
    logic        ref_clk, srst, wp_n_pin, protect_enable, cs_n_pin, sck_pin, si_pin;
    logic        so, so_oe, busy, buffer_clobber, rx_valid;
    logic [7:0]  rx_byte;
    logic [63:0] sector_guard_map, exp_map;
    logic [8:0]  sector_guarded;
    logic [7:0]  exp_q[$], cmd[$];
    logic [31:0] lfsr;
    int          n_mismatch, cmp_count, cycles, n_clobber;

    spr_guard_map #(.ERASE_CNT(CNT), .PROGRAM_CNT(CNT)) i_dut (.ref_clk(ref_clk),
        .srst(srst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin),
        .wp_n_pin(wp_n_pin), .protect_enable(protect_enable), .so(so), .so_oe(so_oe),
        .busy(busy), .sector_guard_map(sector_guard_map),
        .sector_guarded(sector_guarded), .buffer_clobber(buffer_clobber));
    spr_host_model i_host (.ref_clk(ref_clk), .so(so), .cs_n_pin(cs_n_pin),
        .sck_pin(sck_pin), .si_pin(si_pin), .rx_valid(rx_valid), .rx_byte(rx_byte));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Waits for a busy period, or for its absence, then checks the map.
    task automatic run_cycle(input logic want, input logic [63:0] map);
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 12) begin
            @(negedge ref_clk);
            n++;
        end
        check("busy", busy, want);
        while (busy === 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        check("map", sector_guard_map, map);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        cycles++;
        if (buffer_clobber === 1'b1)
            n_clobber++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
        if (rx_valid === 1'b1)
            check("read byte", rx_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end
    initial begin
        srst = 1'b1;
        wp_n_pin = 1'b1;
        protect_enable = 1'b0;
        lfsr = 32'h6c71;
        n_mismatch = 0;
        cmp_count = 0;
        cycles = 0;
        n_clobber = 0;
        repeat (10) @(negedge ref_clk);
        srst = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("shipped map", sector_guard_map, GUARD_MAP_RESET);
        exp_q = '{8'h00, 8'h00, 8'h00, 8'h00};
        i_host.send('{OP_READ, 8'h00, 8'h00, 8'h00}, 4);
        check("so enable", so_oe, 1'b0);
        $display("shipped read done");
        for (int pe = 0; pe < 2; pe++) begin
            protect_enable = pe[0];
            i_host.send('{OP_PREFIX_0, OP_PREFIX_1, OP_PREFIX_2, OP_ERASE_3}, 0);
            run_cycle(1'b1, {MAP_BYTES{BYTE_ERASED}});
            check("guarded", sector_guarded, {9{pe[0]}});
        end
        $display("erase done");
        wp_n_pin = 1'b0;
        i_host.send('{OP_PREFIX_0, OP_PREFIX_1, OP_PREFIX_2, OP_PROGRAM_3, 8'h00}, 0);
        run_cycle(1'b0, {MAP_BYTES{BYTE_ERASED}});
        wp_n_pin = 1'b1;
        i_host.send('{OP_PREFIX_0, OP_PREFIX_1, OP_PREFIX_2, 8'h11}, 0);
        run_cycle(1'b0, {MAP_BYTES{BYTE_ERASED}});
        $display("refusals done");
        cmd = '{OP_PREFIX_0, OP_PREFIX_1, OP_PREFIX_2, OP_PROGRAM_3};
        exp_map = {MAP_BYTES{BYTE_ERASED}};
        for (int i = 0; i < 5; i++) begin
            lfsr = lfsr_next(lfsr);
            cmd.push_back((i == 4) ? ~cmd[4] : {8{lfsr[0]}});
            exp_map[8 * (i % XFER_BYTES) +: 8] = cmd[4 + i];
        end
        i_host.send(cmd, 0);
        run_cycle(1'b1, exp_map);
        for (int i = 0; i < XFER_BYTES; i++) exp_q.push_back(exp_map[8 * i +: 8]);
        i_host.send('{OP_READ, 8'h00, 8'h00, 8'h00}, XFER_BYTES);
        check("reads left", exp_q.size(), 0);
        check("clobber pulses", n_clobber, 2);
        $display("program and read done");
        end_of_test();
    end
endmodule // spr_guard_map_test
